// ---- rtl/pci_status_class_pkg.sv ----
// Constants and types of the configuration status and class registers
`default_nettype none
package pci_status_class_pkg;
	// Configuration space layout
	localparam int          CFG_ADDR_W        = 8;
	localparam int          CFG_DATA_W        = 32;
	localparam logic [7:0]  OFF_CMD_STATUS    = 8'h04;
	localparam logic [7:0]  OFF_BUS_STATUS    = 8'h06;
	localparam logic [7:0]  OFF_REV_CLASS     = 8'h08;
	localparam logic [1:0]  DWORD_ALIGN_MASK  = 2'h3;
	// Status field positions
	localparam int          STS_INT           = 3;
	localparam int          STS_CAP_LIST      = 4;
	localparam int          STS_66MHZ         = 5;
	localparam int          STS_RSVD6         = 6;
	localparam int          STS_FAST_B2B      = 7;
	localparam int          STS_MST_DPE       = 8;
	localparam int          STS_DEVSEL_LO     = 9;
	localparam int          STS_DEVSEL_HI     = 10;
	localparam int          STS_SIG_TABORT    = 11;
	localparam int          STS_RCV_TABORT    = 12;
	localparam int          STS_RCV_MABORT    = 13;
	localparam int          STS_SIG_SERR      = 14;
	localparam int          STS_DET_PAR       = 15;
	// Status reset and fixed values
	localparam logic [2:0]  STS_RSVD_LOW      = 3'h0;
	localparam logic        STS_CAP_LIST_VAL  = 1'h1;
	localparam logic        STS_66MHZ_VAL     = 1'h1;
	localparam logic        STS_FAST_B2B_VAL  = 1'h1;
	localparam logic [1:0]  DEVSEL_MEDIUM     = 2'h1;
	// Class code fields
	localparam logic [7:0]  PROG_IF_EHCI      = 8'h20;
	localparam logic [7:0]  SUBCLASS_USB      = 8'h03;
	localparam logic [7:0]  BASE_CLASS_SERIAL = 8'h0C;
	// Medium decode: answer two clocks after the request
	localparam int          ANSWER_CYCLES     = 2;
	// Configuration access sequencer
	typedef enum logic [1:0] {
		CFG_IDLE,
		CFG_DECODE,
		CFG_ANSWER
	} cfg_state_t;
endpackage
`default_nettype wire

// ---- rtl/pin_sync_if.sv ----
// Carrier between the pin synchroniser and the register bank
`default_nettype none
interface pin_sync_if #(
	parameter int WIDTH = 1
);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] synced;
	modport bank (output raw, input synced);
	modport sync (input raw, output synced);
endinterface
`default_nettype wire

// ---- rtl/pin_sync.sv ----
// Two-stage synchroniser for asynchronous pin inputs
`default_nettype none
module pin_sync #(
	parameter int              WIDTH    = 1,
	parameter logic [WIDTH-1:0] IDLE_VAL = '1
) (
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// Pins
	pin_sync_if.sync  pins
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t state_ff;
	sync_state_t nxt_state;

	if (WIDTH < 1) begin : g_chk
		$error("pin_sync: WIDTH must be at least 1");
	end

	always_comb begin
		nxt_state        = state_ff;
		nxt_state.meta   = pins.raw;
		nxt_state.stable = state_ff.meta;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= '{meta: IDLE_VAL, stable: IDLE_VAL};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign pins.synced = state_ff.stable;
endmodule
`default_nettype wire

// ---- rtl/pci_status_class_regs.sv ----
// Status and revision/class registers of the host controller function
//
// Function
// - Status bit 3 mirrors pending interrupt, resets 0
// - INTx# active only if status set, not disabled
// - Interrupt disable blocks pin, not status bit
// - Status bit 5 fixed one, 66 MHz capable
// - Status bit 7 fixed one, fast back-to-back
// - Bit 8 set: master, PERR#, parity response
// - Bits 10:9 read 01, answer with medium timing
// - Bit 11 set when target abort signalled
// - Bit 12 set when master receives target abort
// - Bit 13 on master abort, never special cycles
// - Bit 14 set whenever SERR# is asserted
// - Bit 15 set on any parity error
// - Revision in bits 7:0 at offset 08h
// - Programming interface bits 15:8 read 20h
// - Subclass bits 23:16 read 03h
// - Base class bits 31:24 read 0Ch
// - Command bit 10 suppresses INTx#
// - Command bit 6 off: no PERR#, flag only
// - SERR# needs command bits 8 and 6
`default_nettype none
module pci_status_class_regs #(
	parameter int         ADDR_W = pci_status_class_pkg::CFG_ADDR_W,
	// Revision value is arbitrary
	parameter logic [7:0] REV_ID = 8'h5A
) (
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	// Configuration access
	input  wire logic              cfg_req_i,
	input  wire logic              cfg_we_i,
	input  wire logic [ADDR_W-1:0] cfg_addr_i,
	input  wire logic [31:0]       cfg_wdata_i,
	input  wire logic [3:0]        cfg_be_i,
	output var  logic              cfg_ack_o,
	output var  logic [31:0]       cfg_rdata_o,
	// Command register controls
	input  wire logic              cmd_parity_resp_i,
	input  wire logic              cmd_serr_en_i,
	input  wire logic              cmd_int_disable_i,
	// Internal interrupt condition
	input  wire logic              int_cond_i,
	// Bus events
	input  wire logic              mst_active_i,
	input  wire logic              mst_read_i,
	input  wire logic              mst_special_cycle_i,
	input  wire logic              data_parity_err_i,
	input  wire logic              addr_parity_err_i,
	input  wire logic              tgt_abort_sent_i,
	input  wire logic              mst_tgt_abort_i,
	input  wire logic              mst_master_abort_i,
	// Parity error pin
	input  wire logic              perr_n_i,
	output var  logic              perr_n_o,
	output var  logic              perr_oe_n_o,
	// System error pin
	output var  logic              serr_n_o,
	output var  logic              serr_oe_n_o,
	// Interrupt pin
	output var  logic              intx_n_o,
	output var  logic              intx_oe_n_o
);
	typedef struct packed {
		pci_status_class_pkg::cfg_state_t state;
		logic [ADDR_W-1:0]                addr;
		logic                             ack;
		logic [31:0]                      rdata;
		logic                             int_sts;
		logic                             intx_drive;
		logic                             perr_drive;
		logic                             serr_drive;
		logic                             mst_dpe;
		logic                             sig_tabort;
		logic                             rcv_tabort;
		logic                             rcv_mabort;
		logic                             sig_serr;
		logic                             det_par;
	} bank_state_t;

	bank_state_t state_ff;
	bank_state_t nxt_state;
	logic        perr_seen;
	logic        mst_dpe_evt;
	logic        serr_evt;
	logic [15:0] sts_word;
	logic [31:0] class_word;
	logic [31:0] rd_word;

	if (ADDR_W < pci_status_class_pkg::CFG_ADDR_W) begin : g_chk
		$error("pci_status_class_regs: ADDR_W too small");
	end

	// PERR# from the bus passes the synchroniser first
	pin_sync_if #(.WIDTH(1)) perr_pin ();
	assign perr_pin.raw = perr_n_i;

	pin_sync #(
		.WIDTH    (1),
		.IDLE_VAL (1'h1)
	) u_perr_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.pins      (perr_pin)
	);

	assign perr_seen = ~perr_pin.synced[0];

	// Master parity error: own PERR# on reads, seen PERR# on writes
	assign mst_dpe_evt = mst_active_i & cmd_parity_resp_i
		& ((mst_read_i & data_parity_err_i)
		| (~mst_read_i & perr_seen));
	// Address parity error reported only when both enables are set
	assign serr_evt = addr_parity_err_i & cmd_serr_en_i
		& cmd_parity_resp_i;

	// Status word assembly
	always_comb begin
		sts_word = 16'h0000;
		sts_word[2:0] = pci_status_class_pkg::STS_RSVD_LOW;
		sts_word[pci_status_class_pkg::STS_INT] = state_ff.int_sts;
		sts_word[pci_status_class_pkg::STS_CAP_LIST] =
			pci_status_class_pkg::STS_CAP_LIST_VAL;
		sts_word[pci_status_class_pkg::STS_66MHZ] =
			pci_status_class_pkg::STS_66MHZ_VAL;
		sts_word[pci_status_class_pkg::STS_RSVD6] = 1'h0;
		sts_word[pci_status_class_pkg::STS_FAST_B2B] =
			pci_status_class_pkg::STS_FAST_B2B_VAL;
		sts_word[pci_status_class_pkg::STS_MST_DPE] = state_ff.mst_dpe;
		sts_word[pci_status_class_pkg::STS_DEVSEL_HI:
			pci_status_class_pkg::STS_DEVSEL_LO] =
			pci_status_class_pkg::DEVSEL_MEDIUM;
		sts_word[pci_status_class_pkg::STS_SIG_TABORT] =
			state_ff.sig_tabort;
		sts_word[pci_status_class_pkg::STS_RCV_TABORT] =
			state_ff.rcv_tabort;
		sts_word[pci_status_class_pkg::STS_RCV_MABORT] =
			state_ff.rcv_mabort;
		sts_word[pci_status_class_pkg::STS_SIG_SERR] = state_ff.sig_serr;
		sts_word[pci_status_class_pkg::STS_DET_PAR] = state_ff.det_par;
	end

	// Revision and class code, all constant
	assign class_word = {
		pci_status_class_pkg::BASE_CLASS_SERIAL,
		pci_status_class_pkg::SUBCLASS_USB,
		pci_status_class_pkg::PROG_IF_EHCI,
		REV_ID
	};

	// Read mux on the dword address; command half is held elsewhere
	always_comb begin
		rd_word = 32'h0000_0000;
		if (state_ff.addr[7:0] == pci_status_class_pkg::OFF_CMD_STATUS) begin
			rd_word[31:16] = sts_word;
		end else if (state_ff.addr[7:0] ==
			pci_status_class_pkg::OFF_REV_CLASS) begin
			rd_word = class_word;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_state.ack = 1'h0;
		// Interrupt status follows the condition regardless of disable
		nxt_state.int_sts = int_cond_i;
		nxt_state.intx_drive = int_cond_i & ~cmd_int_disable_i;
		// PERR# driven only as master on a read with response enabled
		nxt_state.perr_drive = mst_active_i & mst_read_i
			& data_parity_err_i & cmd_parity_resp_i;
		nxt_state.serr_drive = serr_evt;
		// Sticky event flags
		if (mst_dpe_evt) begin
			nxt_state.mst_dpe = 1'h1;
		end
		if (tgt_abort_sent_i) begin
			nxt_state.sig_tabort = 1'h1;
		end
		if (mst_tgt_abort_i) begin
			nxt_state.rcv_tabort = 1'h1;
		end
		if (mst_master_abort_i & ~mst_special_cycle_i) begin
			nxt_state.rcv_mabort = 1'h1;
		end
		if (serr_evt) begin
			nxt_state.sig_serr = 1'h1;
		end
		if (data_parity_err_i | addr_parity_err_i) begin
			nxt_state.det_par = 1'h1;
		end
		// Configuration access with medium decode timing
		case (state_ff.state)
			pci_status_class_pkg::CFG_IDLE: begin
				if (cfg_req_i) begin
					nxt_state.addr = cfg_addr_i &
						~ADDR_W'(pci_status_class_pkg::DWORD_ALIGN_MASK);
					nxt_state.state = pci_status_class_pkg::CFG_DECODE;
				end
			end
			pci_status_class_pkg::CFG_DECODE: begin
				nxt_state.state = pci_status_class_pkg::CFG_ANSWER;
				nxt_state.ack = 1'h1;
				nxt_state.rdata = rd_word;
			end
			pci_status_class_pkg::CFG_ANSWER: begin
				nxt_state.state = pci_status_class_pkg::CFG_IDLE;
			end
			default: begin
				nxt_state.state = pci_status_class_pkg::CFG_IDLE;
			end
		endcase
	end

	// Writes are acknowledged but never alter these registers
	logic unused_wr;
	assign unused_wr = ^{cfg_we_i, cfg_wdata_i, cfg_be_i};

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= '{
				state:      pci_status_class_pkg::CFG_IDLE,
				addr:       '0,
				rdata:      32'h0000_0000,
				default:    1'h0
			};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs straight from the state; pin data lines tied low
	assign cfg_ack_o   = state_ff.ack;
	assign cfg_rdata_o = state_ff.rdata;
	assign perr_n_o    = 1'h0;
	assign perr_oe_n_o = ~state_ff.perr_drive;
	assign serr_n_o    = 1'h0;
	assign serr_oe_n_o = ~state_ff.serr_drive;
	assign intx_n_o    = 1'h0;
	assign intx_oe_n_o = ~state_ff.intx_drive;

	// Checks
	property p_int_follow;
		@(posedge clk_sys_i) disable iff (rst_i)
		sts_word[pci_status_class_pkg::STS_INT] == $past(int_cond_i);
	endproperty
	a_int_follow: assert property (p_int_follow)
		else $error("interrupt status does not follow condition");

	property p_intx_gate;
		@(posedge clk_sys_i) disable iff (rst_i)
		!intx_oe_n_o == (sts_word[pci_status_class_pkg::STS_INT]
			&& !$past(cmd_int_disable_i));
	endproperty
	a_intx_gate: assert property (p_intx_gate)
		else $error("INTx drive not gated by status and disable");

	property p_disable_keeps_sts;
		@(posedge clk_sys_i) disable iff (rst_i)
		(cmd_int_disable_i && int_cond_i) |=>
			sts_word[pci_status_class_pkg::STS_INT] && intx_oe_n_o;
	endproperty
	a_disable_keeps_sts: assert property (p_disable_keeps_sts)
		else $error("interrupt disable altered status or pin");

	property p_fixed_bits;
		@(posedge clk_sys_i) disable iff (rst_i)
		sts_word[7:0] ==? 8'b1011?000;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits)
		else $error("fixed or reserved status bits wrong");

	property p_mst_dpe_cause;
		@(posedge clk_sys_i) disable iff (rst_i)
		$rose(sts_word[pci_status_class_pkg::STS_MST_DPE]) |->
			$past(cmd_parity_resp_i) && $past(mst_active_i);
	endproperty
	a_mst_dpe_cause: assert property (p_mst_dpe_cause)
		else $error("master parity flag set without its causes");

	property p_answer_medium;
		@(posedge clk_sys_i) disable iff (rst_i)
		(cfg_req_i && state_ff.state == pci_status_class_pkg::CFG_IDLE)
			|-> !cfg_ack_o ##1 !cfg_ack_o ##1 cfg_ack_o ##1 !cfg_ack_o;
	endproperty
	a_answer_medium: assert property (p_answer_medium)
		else $error("configuration answer not two cycles later");

	property p_aborts;
		@(posedge clk_sys_i) disable iff (rst_i)
		(tgt_abort_sent_i || mst_tgt_abort_i) |=>
			(sts_word[pci_status_class_pkg::STS_SIG_TABORT]
			|| sts_word[pci_status_class_pkg::STS_RCV_TABORT]);
	endproperty
	a_aborts: assert property (p_aborts)
		else $error("abort event did not set its flag");

	property p_rcv_tabort;
		@(posedge clk_sys_i) disable iff (rst_i)
		mst_tgt_abort_i |=>
			sts_word[pci_status_class_pkg::STS_RCV_TABORT];
	endproperty
	a_rcv_tabort: assert property (p_rcv_tabort)
		else $error("received target abort flag not set");

	property p_intx_disabled;
		@(posedge clk_sys_i) disable iff (rst_i)
		$past(cmd_int_disable_i) |-> intx_oe_n_o;
	endproperty
	a_intx_disabled: assert property (p_intx_disabled)
		else $error("INTx driven while interrupts disabled");

	property p_perr_drive;
		@(posedge clk_sys_i) disable iff (rst_i)
		!perr_oe_n_o |-> $past(cmd_parity_resp_i)
			&& $past(mst_active_i && mst_read_i && data_parity_err_i);
	endproperty
	a_perr_drive: assert property (p_perr_drive)
		else $error("PERR driven without master read parity error");

	property p_det_par_addr;
		@(posedge clk_sys_i) disable iff (rst_i)
		addr_parity_err_i |=>
			sts_word[pci_status_class_pkg::STS_DET_PAR];
	endproperty
	a_det_par_addr: assert property (p_det_par_addr)
		else $error("address parity error not flagged");

	property p_special_cycle;
		@(posedge clk_sys_i) disable iff (rst_i)
		(mst_special_cycle_i
			&& !sts_word[pci_status_class_pkg::STS_RCV_MABORT])
			|=> $stable(sts_word[pci_status_class_pkg::STS_RCV_MABORT]);
	endproperty
	a_special_cycle: assert property (p_special_cycle)
		else $error("special cycle set master abort flag");

	property p_serr_flag;
		@(posedge clk_sys_i) disable iff (rst_i)
		!serr_oe_n_o |-> sts_word[pci_status_class_pkg::STS_SIG_SERR]
			&& $past(cmd_serr_en_i) && $past(cmd_parity_resp_i);
	endproperty
	a_serr_flag: assert property (p_serr_flag)
		else $error("SERR asserted without flag or enables");

	property p_det_par;
		@(posedge clk_sys_i) disable iff (rst_i)
		(data_parity_err_i && !cmd_parity_resp_i) |=>
			sts_word[pci_status_class_pkg::STS_DET_PAR] && perr_oe_n_o;
	endproperty
	a_det_par: assert property (p_det_par)
		else $error("parity error flag or PERR response wrong");

	property p_class_read;
		@(posedge clk_sys_i) disable iff (rst_i)
		(cfg_ack_o
			&& state_ff.addr[7:0] == pci_status_class_pkg::OFF_REV_CLASS)
			|-> cfg_rdata_o == {8'h0C, 8'h03, 8'h20, REV_ID};
	endproperty
	a_class_read: assert property (p_class_read)
		else $error("revision and class word wrong");
endmodule
`default_nettype wire

// ---- dv/cfg_host_model.sv ----
// Configuration host model that issues single configuration accesses
`default_nettype none
module cfg_host_model (
	// Clock
	input  wire logic        clk_sys_i,
	// Configuration access
	output var  logic        cfg_req_o,
	output var  logic        cfg_we_o,
	output var  logic [7:0]  cfg_addr_o,
	output var  logic [31:0] cfg_wdata_o,
	output var  logic [3:0]  cfg_be_o,
	input  wire logic        cfg_ack_i,
	input  wire logic [31:0] cfg_rdata_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cfg_req_o = 1'b0;
		cfg_we_o = 1'b0;
		cfg_addr_o = 8'h00;
		cfg_wdata_o = 32'h00000000;
		cfg_be_o = 4'hF;
	end
	// One request pulse, released lines inverted, bounded wait for the answer
	task automatic access(input logic we, input logic [7:0] addr,
		input logic [31:0] wdata, output logic [31:0] rdata,
		output logic ok);
		int n;
		@(negedge clk_sys_i);
		cfg_req_o = 1'b1;
		cfg_we_o = we;
		cfg_addr_o = addr;
		cfg_wdata_o = wdata;
		@(negedge clk_sys_i);
		cfg_req_o = 1'b0;
		cfg_we_o = ~we;
		cfg_addr_o = ~addr;
		cfg_wdata_o = ~wdata;
		ok = 1'b0;
		rdata = 32'h00000000;
		for (n = 0; n < 8 && !ok; n++) begin
			@(posedge clk_sys_i);
			if (cfg_ack_i === 1'b1) begin
				ok = 1'b1;
				rdata = cfg_rdata_i;
			end
		end
		// Leave on a falling edge so the next request clears the answer slot
		@(negedge clk_sys_i);
	endtask
endmodule
`default_nettype wire

// ---- dv/pci_status_class_regs_tb_top.sv ----
// Testbench of the configuration status and class registers
`default_nettype none
module pci_status_class_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys_i, rst_i, req, we, ack, ok;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  be;
	logic        cmd_par, cmd_serr, cmd_intdis, int_cond;
	logic        mst_active, mst_read, mst_spec, perr_n;
	logic [4:0]  evt;
	logic        perr_o, perr_oe_n, serr_o, serr_oe_n, intx_o, intx_oe_n;
	logic [15:0] exp;
	int          n_fail, checked;
	always #5 clk_sys_i = ~clk_sys_i;
	cfg_host_model u_host (.clk_sys_i(clk_sys_i), .cfg_req_o(req),
		.cfg_we_o(we), .cfg_addr_o(addr), .cfg_wdata_o(wdata),
		.cfg_be_o(be), .cfg_ack_i(ack), .cfg_rdata_i(rdata));
	pci_status_class_regs #(.ADDR_W(8), .REV_ID(8'h3C)) dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_req_i(req),
		.cfg_we_i(we), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
		.cfg_be_i(be), .cfg_ack_o(ack), .cfg_rdata_o(rdata),
		.cmd_parity_resp_i(cmd_par), .cmd_serr_en_i(cmd_serr),
		.cmd_int_disable_i(cmd_intdis), .int_cond_i(int_cond),
		.mst_active_i(mst_active), .mst_read_i(mst_read),
		.mst_special_cycle_i(mst_spec), .data_parity_err_i(evt[4]),
		.addr_parity_err_i(evt[3]), .tgt_abort_sent_i(evt[2]),
		.mst_tgt_abort_i(evt[1]), .mst_master_abort_i(evt[0]),
		.perr_n_i(perr_n), .perr_n_o(perr_o), .perr_oe_n_o(perr_oe_n),
		.serr_n_o(serr_o), .serr_oe_n_o(serr_oe_n), .intx_n_o(intx_o),
		.intx_oe_n_o(intx_oe_n));
	task automatic final_report();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		u_host.access(w, a, wd, d, ok);
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: no answer", $time);
			final_report();
		end
	endtask
	// Read the status half word through its own offset
	task automatic sts(input logic [15:0] want);
		acc(1'b0, 8'h06, 32'h00000000);
		check(d, {want, 16'h0000});
	endtask
	task automatic pins(input logic [1:0] cycles, input logic want);
		repeat (cycles) @(posedge clk_sys_i);
		#1;
		check({31'h0, intx_oe_n}, {31'h0, want});
	endtask
	// One event pulse, pin answer next cycle, then sticky flag read back
	task automatic ev(input logic [4:0] v, input logic [15:0] add,
		input logic serr_want, input logic perr_want);
		@(negedge clk_sys_i);
		evt = v;
		@(posedge clk_sys_i);
		#1;
		check({31'h0, serr_oe_n}, {31'h0, serr_want});
		check({31'h0, perr_oe_n}, {31'h0, perr_want});
		@(negedge clk_sys_i);
		evt = 5'h00;
		exp = exp | add;
		sts(exp);
	endtask
	task automatic perr_pulse();
		@(negedge clk_sys_i);
		perr_n = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		perr_n = 1'b1;
		repeat (3) @(posedge clk_sys_i);
	endtask
	initial begin
		{clk_sys_i, cmd_par, cmd_serr, cmd_intdis, int_cond} = 5'h00;
		{mst_active, mst_read, mst_spec, evt} = 8'h00;
		perr_n = 1'b1;
		n_fail = 0;
		checked = 0;
		exp = 16'h02B0;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		acc(1'b0, 8'h08, 32'h00000000);
		check(d, 32'h0C03203C);
		acc(1'b1, 8'h08, 32'hFFFFFFFF);
		acc(1'b0, 8'h08, 32'h00000000);
		check(d, 32'h0C03203C);
		acc(1'b1, 8'h04, 32'hFFFFFFFF);
		sts(16'h02B0);
		acc(1'b0, 8'h0C, 32'h00000000);
		check(d, 32'h00000000);
		check({29'h0, perr_o, serr_o, intx_o}, 32'h0);
		$display("test registers done");
		int_cond = 1'b1;
		pins(2'h2, 1'b0);
		sts(16'h02B8);
		cmd_intdis = 1'b1;
		pins(2'h2, 1'b1);
		sts(16'h02B8);
		int_cond = 1'b0;
		cmd_intdis = 1'b0;
		pins(2'h2, 1'b1);
		sts(16'h02B0);
		$display("test interrupt done");
		{mst_active, mst_read, cmd_serr, mst_spec} = 4'hF;
		ev(5'h01, 16'h0000, 1'b1, 1'b1);
		mst_spec = 1'b0;
		ev(5'h01, 16'h2000, 1'b1, 1'b1);
		ev(5'h04, 16'h0800, 1'b1, 1'b1);
		ev(5'h02, 16'h1000, 1'b1, 1'b1);
		ev(5'h10, 16'h8000, 1'b1, 1'b1);
		ev(5'h08, 16'h0000, 1'b1, 1'b1);
		cmd_par = 1'b1;
		ev(5'h08, 16'h4000, 1'b0, 1'b1);
		ev(5'h10, 16'h0100, 1'b1, 1'b0);
		$display("test events done");
		@(negedge clk_sys_i);
		rst_i = 1'b1;
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		exp = 16'h02B0;
		sts(exp);
		{mst_active, mst_read} = 2'h0;
		perr_pulse();
		sts(exp);
		mst_active = 1'b1;
		perr_pulse();
		exp = exp | 16'h0100;
		sts(exp);
		cmd_serr = 1'b0;
		ev(5'h08, 16'h8000, 1'b1, 1'b1);
		$display("test write parity done");
		final_report();
	end
endmodule
`default_nettype wire
